// file: eid_core.sv
// Overview of operation
// - Opcode 0001 10da ffffffff XORs the accumulator with a file register in one word and one cycle.
// - A clear destination bit sends the XOR result to the accumulator, a set one back to the file register.
// - A clear bank-access bit addresses the access bank, a set one uses the bank select register.
// - With the extended set on and bank-access clear, a field at or below 5Fh is an offset from the software stack pointer.
// - The XOR changes only the negative and zero flags.
// - The extended features are off after reset unless the enable bit is set.
// - When enabled, eight extra instructions and indexed literal offset addressing are available.
// - 1110 1000 ffkk kkkk adds and 1110 1001 ffkk kkkk subtracts a literal on a pointer in one cycle, no flags.
// - A select field of 11 works on the software stack pointer, then returns, taking two cycles.
// - Opcode 0000 0000 0001 0100 calls through the accumulator in two cycles with no flag change.
// - 1110 1010 kkkk kkkk stores the literal at the software stack pointer and decrements it in one cycle.
// - Add to pointer adds the unsigned 6-bit literal to the pointer the two-bit field selects.
// - The return variant loads the PC from the return stack top on the same edge as the pointer update, then idles a cycle.
// - The call pushes PC + 2, loads the PC from accumulator and the latches, then idles a cycle.
`timescale 1ns/1ps
module eid_core (
  input wire logic I_CLK,
  input wire logic I_RST,
  input wire logic I_EXT_SET_ENABLE,
  input wire logic [15:0] I_INSTR,
  input wire logic I_INSTR_VALID,
  input eid_pkg::eid_cfg_s I_CFG,
  input wire logic [20:0] I_RET_TOP,
  input wire logic I_ACC_LOAD,
  input wire logic [7:0] I_ACC_DATA,
  output logic O_READY,
  output logic O_EXT_ENABLED,
  output logic O_WANT_WORD,
  output logic O_WORD_TAKEN,
  output logic [1:0] O_PHASE,
  output logic [7:0] O_ACC,
  output logic [4:0] O_STATUS,
  output logic [11:0] O_FSR0,
  output logic [11:0] O_FSR1,
  output logic [11:0] O_SOFTWARE_STACK_POINTER,
  output logic [20:0] O_PC,
  output logic O_PUSH,
  output logic [20:0] O_PUSH_ADDR,
  output logic O_POP,
  output logic O_MEM_WE,
  output logic [11:0] O_MEM_ADDR,
  output logic [7:0] O_MEM_WDATA
);
  import eid_pkg::*;

  eid_state_s st_reg;
  eid_state_s st_next;
  logic [7:0] mem_rdata;

  // ==========================================================
  // Data memory
  // ==========================================================
  eid_data_mem u_mem (
    .i_clk(I_CLK),
    .i_we(st_reg.mem_we),
    .i_addr(st_reg.mem_addr),
    .i_wdata(st_reg.mem_wdata),
    .o_rdata(mem_rdata)
  );

  // ==========================================================
  // Helpers
  // ==========================================================
  function automatic logic [11:0] file_addr(
    input logic [7:0] f,
    input logic banked,
    input logic ext,
    input logic [3:0] bank,
    input logic [11:0] sw_stack
  );
    logic [11:0] a;
    a = {bank, f};
    if (banked) begin
      a = {bank, f};
    end else if (ext && (f <= ILO_LIMIT)) begin
      a = sw_stack + {4'h0, f};
    end else if (f[ACCESS_SPLIT_BIT]) begin
      a = {ACCESS_HIGH_BANK, f};
    end else begin
      a = {ACCESS_LOW_BANK, f};
    end
    return a;
  endfunction : file_addr

  function automatic eid_op_e decode(
    input logic [15:0] w,
    input logic ext
  );
    eid_op_e op;
    op = OP_NOP;
    if (w[15:10] == OPC_XOR_FILE) begin
      op = OP_XOR;
    end else if (!ext) begin
      op = OP_NOP;
    end else if (w[15:9] == OPC_PTR_ARITH) begin
      if (w[7:6] == PTR_SEL_STACK) begin
        op = w[PTR_SUB_BIT] ? OP_SUB_RET : OP_ADD_RET;
      end else begin
        op = w[PTR_SUB_BIT] ? OP_SUB_PTR : OP_ADD_PTR;
      end
    end else if (w == OPC_CALL_VIA_ACC) begin
      op = OP_CALL_VIA_ACCUMULATOR;
    end else if (w[15:8] == OPC_PUSH_LITERAL) begin
      op = OP_PUSH_LITERAL;
    end else if (w[15:8] == OPC_MOVE_INDEXED) begin
      op = w[MOVE_KIND_BIT] ? OP_MOVE_INDEXED_TO_INDEXED : OP_MOVE_INDEXED_TO_ABSOLUTE;
    end
    return op;
  endfunction : decode

  // ==========================================================
  // Next state
  // ==========================================================
  always_comb begin
    logic [11:0] sw;
    logic [11:0] lit;
    logic [1:0] sel;
    logic [11:0] dest;
    sw = st_reg.file_select_pointer[PTR_SEL_SW_STACK];
    lit = {6'h00, st_reg.instr[5:0]};
    sel = st_reg.instr[7:6];
    dest = st_reg.word2[11:0];
    st_next = st_reg;
    st_next.taken = 1'b0;
    st_next.push = 1'b0;
    st_next.pop = 1'b0;
    st_next.mem_we = 1'b0;

    // Enable pin is asynchronous: synchronise, then freeze once
    st_next.ext_sync1 = I_EXT_SET_ENABLE;
    st_next.ext_sync2 = st_reg.ext_sync1;
    if (!st_reg.ext_caught) begin
      if (st_reg.settle == EXT_SETTLE) begin
        st_next.ext_en = st_reg.ext_sync2;
        st_next.ext_caught = 1'b1;
      end else begin
        st_next.settle = st_reg.settle + 2'h1;
      end
    end

    case (st_reg.phase)
      PH_Q1: begin
        st_next.phase = PH_Q2;
        if (!st_reg.cyc2) begin
          st_next.op = OP_IDLE;
          if (st_reg.ext_caught && I_INSTR_VALID) begin
            st_next.taken = 1'b1;
            st_next.instr = I_INSTR;
            st_next.op = decode(I_INSTR, st_reg.ext_en);
            st_next.mem_addr = file_addr(I_INSTR[7:0],
              I_INSTR[BANK_ACCESS_BIT], st_reg.ext_en,
              I_CFG.bank_select, sw);
          end else if (st_reg.ext_caught && I_ACC_LOAD) begin
            st_next.acc = I_ACC_DATA;
          end
        end else if ((st_reg.op == OP_MOVE_INDEXED_TO_ABSOLUTE) ||
                     (st_reg.op == OP_MOVE_INDEXED_TO_INDEXED)) begin
          // Second word stalls the phase until it arrives
          if (I_INSTR_VALID) begin
            st_next.taken = 1'b1;
            st_next.word2 = I_INSTR;
            st_next.word2_ok = (I_INSTR[15:12] == OPC_SECOND_WORD);
            st_next.mem_addr = sw + {5'h00, st_reg.instr[6:0]};
          end else begin
            st_next.phase = PH_Q1;
          end
        end
      end
      PH_Q2: begin
        st_next.phase = PH_Q3;
      end
      PH_Q3: begin
        st_next.phase = PH_Q4;
        if (!st_reg.cyc2) begin
          case (st_reg.op)
            OP_XOR: begin
              st_next.result = st_reg.acc ^ mem_rdata;
              if (st_reg.instr[DEST_BIT]) begin
                st_next.mem_we = 1'b1;
                st_next.mem_wdata = st_reg.acc ^ mem_rdata;
              end
            end
            OP_CALL_VIA_ACCUMULATOR: begin
              st_next.push = 1'b1;
              st_next.push_addr = st_reg.pc + PC_STEP;
            end
            OP_PUSH_LITERAL: begin
              st_next.mem_we = 1'b1;
              st_next.mem_addr = sw;
              st_next.mem_wdata = st_reg.instr[7:0];
            end
            default: begin
            end
          endcase
        end else if (((st_reg.op == OP_MOVE_INDEXED_TO_ABSOLUTE) ||
                      (st_reg.op == OP_MOVE_INDEXED_TO_INDEXED)) && st_reg.word2_ok) begin
          st_next.mem_we = 1'b1;
          st_next.mem_wdata = mem_rdata;
          if (st_reg.op == OP_MOVE_INDEXED_TO_ABSOLUTE) begin
            st_next.mem_addr = dest;
          end else begin
            st_next.mem_addr = sw + {5'h00, dest[6:0]};
          end
        end
      end
      PH_Q4: begin
        st_next.phase = PH_Q1;
        if (st_reg.cyc2) begin
          // Second cycle of a two-cycle instruction
          st_next.cyc2 = 1'b0;
          if ((st_reg.op == OP_MOVE_INDEXED_TO_ABSOLUTE) || (st_reg.op == OP_MOVE_INDEXED_TO_INDEXED)) begin
            st_next.pc = st_reg.pc + PC_STEP;
          end
          st_next.op = OP_IDLE;
        end else begin
          case (st_reg.op)
            OP_IDLE: begin
            end
            OP_XOR: begin
              st_next.status[ST_N] = st_reg.result[7];
              st_next.status[ST_Z] = (st_reg.result == 8'h00);
              if (!st_reg.instr[DEST_BIT]) begin
                st_next.acc = st_reg.result;
              end
              st_next.pc = st_reg.pc + PC_STEP;
            end
            OP_ADD_PTR: begin
              st_next.file_select_pointer[sel] = st_reg.file_select_pointer[sel] + lit;
              st_next.pc = st_reg.pc + PC_STEP;
            end
            OP_SUB_PTR: begin
              st_next.file_select_pointer[sel] = st_reg.file_select_pointer[sel] - lit;
              st_next.pc = st_reg.pc + PC_STEP;
            end
            OP_ADD_RET: begin
              st_next.file_select_pointer[PTR_SEL_SW_STACK] = sw + lit;
              st_next.pc = I_RET_TOP;
              st_next.pop = 1'b1;
              st_next.cyc2 = 1'b1;
            end
            OP_SUB_RET: begin
              st_next.file_select_pointer[PTR_SEL_SW_STACK] = sw - lit;
              st_next.pc = I_RET_TOP;
              st_next.pop = 1'b1;
              st_next.cyc2 = 1'b1;
            end
            OP_CALL_VIA_ACCUMULATOR: begin
              st_next.pc = {I_CFG.pc_upper_latch, I_CFG.pc_high_latch,
                            st_reg.acc};
              st_next.cyc2 = 1'b1;
            end
            OP_PUSH_LITERAL: begin
              st_next.file_select_pointer[PTR_SEL_SW_STACK] = sw - FSR_DEC;
              st_next.pc = st_reg.pc + PC_STEP;
            end
            OP_MOVE_INDEXED_TO_ABSOLUTE, OP_MOVE_INDEXED_TO_INDEXED: begin
              st_next.pc = st_reg.pc + PC_STEP;
              st_next.cyc2 = 1'b1;
            end
            default: begin
              st_next.pc = st_reg.pc + PC_STEP;
            end
          endcase
        end
      end
      default: begin
        st_next.phase = PH_Q1;
      end
    endcase

    st_next.want = (st_next.phase == PH_Q1) && st_next.ext_caught &&
                   (!st_next.cyc2 || (st_next.op == OP_MOVE_INDEXED_TO_ABSOLUTE) ||
                    (st_next.op == OP_MOVE_INDEXED_TO_INDEXED));
  end

  // ==========================================================
  // State register
  // ==========================================================
  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      st_reg <= '0;
      st_reg.phase <= PH_Q1;
      st_reg.op <= OP_IDLE;
      st_reg.acc <= ACC_RST;
      st_reg.status <= STATUS_RST;
      st_reg.file_select_pointer <= {FSR_RST, FSR_RST, FSR_RST};
      st_reg.pc <= PC_RST;
      st_reg.ext_en <= 1'b0;
    end else begin
      st_reg <= st_next;
    end
  end

  // ==========================================================
  // Outputs
  // ==========================================================
  assign O_READY = st_reg.ext_caught;
  assign O_EXT_ENABLED = st_reg.ext_en;
  assign O_WANT_WORD = st_reg.want;
  assign O_WORD_TAKEN = st_reg.taken;
  assign O_PHASE = st_reg.phase;
  assign O_ACC = st_reg.acc;
  assign O_STATUS = st_reg.status;
  assign O_FSR0 = st_reg.file_select_pointer[0];
  assign O_FSR1 = st_reg.file_select_pointer[1];
  assign O_SOFTWARE_STACK_POINTER = st_reg.file_select_pointer[2];
  assign O_PC = st_reg.pc;
  assign O_PUSH = st_reg.push;
  assign O_PUSH_ADDR = st_reg.push_addr;
  assign O_POP = st_reg.pop;
  assign O_MEM_WE = st_reg.mem_we;
  assign O_MEM_ADDR = st_reg.mem_addr;
  assign O_MEM_WDATA = st_reg.mem_wdata;

endmodule : eid_core

// file: eid_core_chk.sv
`timescale 1ns/1ps
module eid_core_chk (
  input wire logic I_CLK,
  input wire logic I_RST,
  input wire logic I_INSTR_VALID,
  input wire logic [20:0] I_RET_TOP,
  input wire logic O_READY,
  input wire logic O_EXT_ENABLED,
  input wire logic O_WANT_WORD,
  input wire logic O_WORD_TAKEN,
  input wire logic [1:0] O_PHASE,
  input wire logic [4:0] O_STATUS,
  input wire logic [20:0] O_PC,
  input wire logic O_PUSH,
  input wire logic [20:0] O_PUSH_ADDR,
  input wire logic O_POP,
  input wire logic O_MEM_WE
);
  import eid_pkg::*;
  // ========================================
  // Port relations
  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (I_RST);
  a_word_take: assert property (O_WANT_WORD && I_INSTR_VALID &&
    O_PHASE == 2'h0 |=> O_WORD_TAKEN) else $error("word not taken");
  a_take_phase: assert property (O_WORD_TAKEN |-> O_PHASE == 2'h1)
    else $error("take pulse off phase");
  // Only Q1 may stall, the other phases always advance
  a_phase_walk: assert property (O_PHASE != 2'h0 |=>
    O_PHASE == $past(O_PHASE) + 2'h1) else $error("phase skipped");
  a_write_q4: assert property (O_MEM_WE |-> O_PHASE == 2'h3)
    else $error("write outside Q4");
  a_write_once: assert property (O_MEM_WE |=> !O_MEM_WE)
    else $error("write strobe too long");
  a_flags_kept: assert property (O_STATUS[3] == 1'b0 &&
    O_STATUS[1:0] == 2'h0) else $error("foreign flag changed");
  a_enable_frozen: assert property (O_READY && $past(O_READY) |->
    $stable(O_EXT_ENABLED)) else $error("enable changed");
  a_off_no_stack: assert property (O_READY && !O_EXT_ENABLED |->
    !O_PUSH && !O_POP) else $error("extended op while off");
  a_push_addr: assert property (O_PUSH |->
    O_PUSH_ADDR == O_PC + PC_STEP) else $error("bad return address");
  a_call_idle: assert property (O_PUSH |=> !O_WANT_WORD [*4])
    else $error("call not two cycles");
  a_pop_pc: assert property (O_POP |-> O_PC == $past(I_RET_TOP))
    else $error("return target wrong");
  a_ret_idle: assert property (O_POP |-> !O_WANT_WORD [*4])
    else $error("return not two cycles");
  c_push: cover property (O_PUSH);
  c_pop: cover property (O_POP);
  c_write: cover property (O_MEM_WE);
endmodule : eid_core_chk

bind eid_core eid_core_chk eid_core_chk_i (.I_CLK(I_CLK), .I_RST(I_RST),
  .I_INSTR_VALID(I_INSTR_VALID), .I_RET_TOP(I_RET_TOP),
  .O_READY(O_READY), .O_EXT_ENABLED(O_EXT_ENABLED),
  .O_WANT_WORD(O_WANT_WORD), .O_WORD_TAKEN(O_WORD_TAKEN),
  .O_PHASE(O_PHASE), .O_STATUS(O_STATUS), .O_PC(O_PC), .O_PUSH(O_PUSH),
  .O_PUSH_ADDR(O_PUSH_ADDR), .O_POP(O_POP), .O_MEM_WE(O_MEM_WE));

// file: eid_data_mem.sv
`timescale 1ns/1ps
module eid_data_mem (
  input wire logic i_clk,
  input wire logic i_we,
  input wire logic [11:0] i_addr,
  input wire logic [7:0] i_wdata,
  output logic [7:0] o_rdata
);
  import eid_pkg::*;

  logic [7:0] mem [MEM_DEPTH];

  // Read-before-write: a write in the same edge returns old data
  always_ff @(posedge i_clk) begin
    if (i_we) begin
      mem[i_addr] <= i_wdata;
    end
    o_rdata <= mem[i_addr];
  end

endmodule : eid_data_mem

// file: eid_pkg.sv
package eid_pkg;

  // ==========================================================
  // Opcode patterns
  // ==========================================================
  localparam logic [5:0] OPC_XOR_FILE = 6'h06;
  localparam logic [6:0] OPC_PTR_ARITH = 7'h74;
  localparam logic [7:0] OPC_PUSH_LITERAL = 8'hEA;
  localparam logic [7:0] OPC_MOVE_INDEXED = 8'hEB;
  localparam logic [15:0] OPC_CALL_VIA_ACC = 16'h0014;
  localparam logic [3:0] OPC_SECOND_WORD = 4'hF;

  // ==========================================================
  // Field positions
  // ==========================================================
  localparam int DEST_BIT = 9;
  localparam int BANK_ACCESS_BIT = 8;
  localparam int PTR_SUB_BIT = 8;
  localparam int MOVE_KIND_BIT = 7;
  localparam int ACCESS_SPLIT_BIT = 7;
  localparam int ST_Z = 2;
  localparam int ST_N = 4;

  // ==========================================================
  // Addressing constants
  // ==========================================================
  localparam logic [7:0] ILO_LIMIT = 8'h5F;
  localparam logic [1:0] PTR_SEL_STACK = 2'h3;
  localparam logic [1:0] PTR_SEL_SW_STACK = 2'h2;
  localparam logic [3:0] ACCESS_LOW_BANK = 4'h0;
  localparam logic [3:0] ACCESS_HIGH_BANK = 4'hF;
  localparam int MEM_DEPTH = 4096;

  // ==========================================================
  // Reset values and counts
  // ==========================================================
  localparam logic [7:0] ACC_RST = 8'h00;
  localparam logic [4:0] STATUS_RST = 5'h00;
  localparam logic [11:0] FSR_RST = 12'h000;
  localparam logic [20:0] PC_RST = 21'h00_0000;
  localparam logic [20:0] PC_STEP = 21'h00_0002;
  localparam logic [11:0] FSR_DEC = 12'h001;
  localparam logic [1:0] EXT_SETTLE = 2'h2;

  // ==========================================================
  // Types
  // ==========================================================
  typedef enum logic [1:0] {PH_Q1, PH_Q2, PH_Q3, PH_Q4} eid_phase_e;

  typedef enum logic [3:0] {
    OP_IDLE, OP_NOP, OP_XOR, OP_ADD_PTR, OP_SUB_PTR, OP_ADD_RET,
    OP_SUB_RET, OP_CALL_VIA_ACCUMULATOR, OP_PUSH_LITERAL, OP_MOVE_INDEXED_TO_ABSOLUTE, OP_MOVE_INDEXED_TO_INDEXED
  } eid_op_e;

  typedef struct packed {
    logic [3:0] bank_select;
    logic [7:0] pc_high_latch;
    logic [4:0] pc_upper_latch;
  } eid_cfg_s;

  typedef struct packed {
    logic ext_sync1;
    logic ext_sync2;
    logic [1:0] settle;
    logic ext_caught;
    logic ext_en;
    eid_phase_e phase;
    logic cyc2;
    eid_op_e op;
    logic [15:0] instr;
    logic [15:0] word2;
    logic word2_ok;
    logic [7:0] result;
    logic [7:0] acc;
    logic [4:0] status;
    logic [2:0][11:0] file_select_pointer;
    logic [20:0] pc;
    logic taken;
    logic want;
    logic push;
    logic [20:0] push_addr;
    logic pop;
    logic [11:0] mem_addr;
    logic mem_we;
    logic [7:0] mem_wdata;
  } eid_state_s;

endpackage : eid_pkg

// file: extended_instruction_decode_test.sv
`timescale 1ns/1ps
module extended_instruction_decode_test;
  import eid_pkg::*;
  // ========================================
  // Stimulus and observed ports
  localparam int LIMIT = 3000;
  logic i_clk = 1'b0, i_rst = 1'b1, ext = 1'b1, vld = 1'b0, ld = 1'b0;
  logic [15:0] instr = 16'h0000;
  logic [7:0] acc_d = 8'h00;
  logic [20:0] rtop = 21'h0_0000;
  eid_cfg_s cfg = '{4'h7, 8'h10, 5'h00};
  logic rdy, ext_on, want, tkn, push, pop, we;
  logic [1:0] ph;
  logic [7:0] acc, wdat, wd, n8;
  logic [7:0] wn = 8'h00;
  logic [4:0] st;
  logic [11:0] f0, f1, f2, wadr, wa;
  logic [20:0] pc, paddr, pa, pc0;
  wire logic [35:0] fs = {f2, f1, f0};
  logic [15:0] p_op[3] = '{16'hE83F, 16'hE941, 16'hE8A3};
  logic [11:0] p_exp[3] = '{12'h03F, 12'hFFF, 12'h022};
  logic [15:0] a_op[3] = '{16'h1B20, 16'h1A80, 16'h1A60};
  logic [11:0] a_exp[3] = '{12'h720, 12'hF80, 12'h060};
  int bad_count = 0, checks_done = 0, cyc = 0;

  eid_core eid_core_i (.I_CLK(i_clk), .I_RST(i_rst),
    .I_EXT_SET_ENABLE(ext), .I_INSTR(instr), .I_INSTR_VALID(vld),
    .I_CFG(cfg), .I_RET_TOP(rtop), .I_ACC_LOAD(ld), .I_ACC_DATA(acc_d),
    .O_READY(rdy), .O_EXT_ENABLED(ext_on), .O_WANT_WORD(want),
    .O_WORD_TAKEN(tkn), .O_PHASE(ph), .O_ACC(acc), .O_STATUS(st),
    .O_FSR0(f0), .O_FSR1(f1), .O_SOFTWARE_STACK_POINTER(f2), .O_PC(pc), .O_PUSH(push),
    .O_PUSH_ADDR(paddr), .O_POP(pop), .O_MEM_WE(we),
    .O_MEM_ADDR(wadr), .O_MEM_WDATA(wdat));

  always #25 i_clk = ~i_clk;

  // Memory is internal, so writes are seen only at the strobe
  always @(posedge i_clk) begin
    cyc <= cyc + 1;
    if (we === 1'b1) begin
      wa <= wadr;
      wd <= wdat;
      wn <= wn + 8'h01;
    end
    if (push === 1'b1) pa <= paddr;
    if (cyc == LIMIT) begin
      bad_count++;
      give_verdict();
    end
  end

  task automatic step();
    @(posedge i_clk);
    #1;
  endtask : step

  task automatic chk(input logic [20:0] g, input logic [20:0] e);
    checks_done++;
    if (g !== e) begin
      bad_count++;
      $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk

  // Returns in Q1 right after results land
  task automatic run(input logic [15:0] w);
    pc0 = pc;
    instr = w;
    vld = 1'b1;
    while (want !== 1'b1) step();
    step();
    vld = 1'b0;
    // Take edge ends Q1; results land on the third edge after it
    repeat (3) step();
  endtask : run

  task automatic load_acc(input logic [7:0] v);
    while (want !== 1'b1) step();
    ld = 1'b1;
    acc_d = v;
    step();
    ld = 1'b0;
    repeat (3) step();
    chk(acc, v);
  endtask : load_acc

  task automatic reset_to(input logic en);
    i_rst = 1'b1;
    ext = en;
    repeat (20) step();
    i_rst = 1'b0;
    repeat (4) step();
  endtask : reset_to

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : give_verdict

  initial begin
    reset_to(1'b1);
    chk(ext_on, 1'b1);
    chk(rdy, 1'b1);
    run(16'hEAA5);
    chk(f2, 12'hFFF);
    chk({wa, wd}, 20'h0_00A5);
    chk(want, 1'b1);
    chk(ph, 2'h0);
    $display("test push literal done");
    load_acc(8'h3C);
    run(16'h1A01);
    chk({wa, wd}, 20'h0_0099);
    chk(st, 5'h10);
    chk(acc, 8'h3C);
    chk(pc, pc0 + 21'h2);
    chk(want, 1'b1);
    n8 = wn;
    run(16'h1801);
    chk(acc, 8'hA5);
    chk(wn, n8);
    load_acc(8'h99);
    run(16'h1801);
    chk(st, 5'h04);
    $display("test xor done");
    for (int i = 0; i < 3; i++) begin
      run(p_op[i]);
      chk(fs[i*12 +: 12], p_exp[i]);
      chk(st, 5'h04);
      chk(want, 1'b1);
    end
    rtop = 21'h1_2344;
    run(16'hE8C5);
    chk(f2, 12'h027);
    chk(pc, 21'h1_2344);
    chk(want, 1'b0);
    rtop = 21'h0_0400;
    run(16'hE9C2);
    chk(f2, 12'h025);
    chk(pc, 21'h0_0400);
    $display("test pointer ops done");
    load_acc(8'h06);
    run(16'h0014);
    chk(pa, pc0 + 21'h2);
    chk(pc, 21'h0_1006);
    chk(want, 1'b0);
    chk(st, 5'h04);
    $display("test call done");
    run(16'hEA5A);
    run(16'hEB01);
    run(16'hF123);
    chk({wa, wd}, 20'h1_235A);
    chk(pc, pc0 + 21'h2);
    run(16'hEB81);
    run(16'hF010);
    chk({wa, wd}, 20'h0_345A);
    $display("test moves done");
    for (int i = 0; i < 3; i++) begin
      run(a_op[i]);
      chk(wa, a_exp[i]);
    end
    $display("test banks done");
    reset_to(1'b0);
    chk(ext_on, 1'b0);
    n8 = wn;
    run(16'hEAA5);
    chk(wn, n8);
    chk(f2, 12'h000);
    chk(pc, pc0 + 21'h2);
    run(16'h0014);
    chk(pc, pc0 + 21'h2);
    chk(want, 1'b1);
    run(16'h1A01);
    chk(wa, 12'h001);
    $display("test disabled done");
    give_verdict();
  end
endmodule : extended_instruction_decode_test
